// file: verilog/csf_status_flags.sv
// Status flag bank and fault routing register of a multi-channel converter.
// Assumes a register port delivering one-cycle read/write strobes with an address,
// and conversion events arriving as one-cycle pulses on the same clock.
`timescale 1ns/1ps

// Notes on behaviour
// - Two-bit field names the channel that raised the latched flag or error.
// - Errors stay latched until a flag read or source channel result read.
// - Watchdog flag sets on any built channel timeout, active or not, else reads zero.
// - Amplitude-high flag sets on any built channel warning, active or not, since last read.
// - Amplitude-low flag sets on any built channel warning, active or not, since last read.
// - Ready flag rises on a new result, stays low otherwise.
// - Single-channel mode: ready flag on each result of the selected channel.
// - Sequential mode: ready flag only once every active channel has fresh results.
// - One unread flag per channel, channel 0 at bit 3 down to bit 0.
// - Two-channel build never reports channel codes 2 or 3 or their flags.
// - Watchdog routed to interrupt asserts the low interrupt output on timeout.
// - Ready routed to interrupt asserts the low interrupt output when ready.
// - Watchdog routed to results flags it in the causing channel result.
// - Interrupt output asserts on a routed watchdog or ready event unless disabled.
module csf_status_flags #(
	parameter int NUM_CHAN = csf_pkg::NUM_CHAN
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// Result register reads, one strobe per channel
	input  wire logic [3:0]  result_read,
	// Conversion core events, one-cycle pulses per channel
	input  wire logic [3:0]  conv_done,
	input  wire logic [3:0]  wd_timeout_evt,
	input  wire logic [3:0]  amp_high_evt,
	input  wire logic [3:0]  amp_low_evt,
	// Conversion setup
	input  csf_pkg::csf_mode_t conv_mode,
	input  wire logic [1:0]  active_chan,
	input  wire logic [3:0]  active_mask,
	input  wire logic        irq_output_disable,
	// Interrupt and result-register fault marks
	output logic             irq_out_n,
	output logic      [3:0]  result_wd_mark,
	output logic      [3:0]  result_amp_mark
);
	// Flag state
	logic [1:0]  error_source_channel_r;
	logic        watchdog_timeout_flag_r;
	logic        amplitude_high_warning_r;
	logic        amplitude_low_warning_r;
	logic        conversion_ready_flag_r;
	logic [3:0]  unread_r;
	logic [3:0]  fresh_r;
	logic        watchdog_to_result_enable_r;
	logic        amp_high_to_result_enable_r;
	logic        amp_low_to_result_enable_r;
	logic        watchdog_to_irq_enable_r;
	logic        ready_to_irq_enable_r;
	logic        irq_r;
	logic [15:0] reg_rdata_r;
	logic [15:0] flags_word;
	logic [15:0] routing_word;
	logic [3:0]  chan_ok;
	logic [3:0]  wd_ev;
	logic [3:0]  ah_ev;
	logic [3:0]  al_ev;
	logic [3:0]  done_ev;
	logic [3:0]  err_ev;
	logic [1:0]  err_sel;
	logic [3:0]  fresh_nxt;
	logic [3:0]  act_ok;
	logic        flags_rd;
	logic        clear_err;
	logic        err_latched;
	logic        rdy_set;

	// Channels beyond the build width are masked off at the source
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_chan
			assign chan_ok[g] = (g < NUM_CHAN);
		end
	endgenerate
	assign wd_ev   = wd_timeout_evt & chan_ok;
	assign ah_ev   = amp_high_evt & chan_ok;
	assign al_ev   = amp_low_evt & chan_ok;
	assign done_ev = conv_done & chan_ok;
	assign act_ok  = active_mask & chan_ok;
	assign err_ev  = wd_ev | ah_ev | al_ev;

	// Lowest-numbered faulting channel wins when several fault together
	always_comb begin
		err_sel = csf_pkg::CHAN_RST;
		for (int i = 3; i >= 0; i--) begin
			if (err_ev[i]) begin
				err_sel = 2'(i);
			end
		end
	end

	// Release of latched errors by a flag read or a read of the source result
	assign flags_rd    = reg_rd && (reg_addr == csf_pkg::ADDR_FLAGS);
	assign clear_err   = flags_rd || result_read[error_source_channel_r];
	assign err_latched = watchdog_timeout_flag_r | amplitude_high_warning_r | amplitude_low_warning_r;

	// Error flags: a new event beats a clear in the same cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_timeout_flag_r  <= 1'b0;
			amplitude_high_warning_r <= 1'b0;
			amplitude_low_warning_r  <= 1'b0;
		end else begin
			watchdog_timeout_flag_r  <= (|wd_ev) | (watchdog_timeout_flag_r & ~clear_err);
			amplitude_high_warning_r <= (|ah_ev) | (amplitude_high_warning_r & ~clear_err);
			amplitude_low_warning_r  <= (|al_ev) | (amplitude_low_warning_r & ~clear_err);
		end
	end

	// Source channel is frozen while an error is held, so it stays meaningful
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			error_source_channel_r <= csf_pkg::CHAN_RST;
		end else if ((|err_ev) && (!err_latched || clear_err)) begin
			error_source_channel_r <= err_sel;
		end
	end

	// Ready condition per conversion scheme
	always_comb begin
		fresh_nxt = fresh_r | (done_ev & act_ok);
		if (conv_mode == csf_pkg::CSF_SINGLE) begin
			rdy_set = done_ev[active_chan];
		end else begin
			rdy_set = (act_ok != 4'h0) && ((fresh_nxt & act_ok) == act_ok);
		end
	end

	// Sequence tracker restarts once the whole set has been reported
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fresh_r <= csf_pkg::FLAGS4_RST;
		end else if (conv_mode == csf_pkg::CSF_SINGLE || rdy_set) begin
			fresh_r <= csf_pkg::FLAGS4_RST;
		end else begin
			fresh_r <= fresh_nxt;
		end
	end

	// Ready flag, cleared by a flag read unless a new result lands
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			conversion_ready_flag_r <= 1'b0;
		end else begin
			conversion_ready_flag_r <= rdy_set | (conversion_ready_flag_r & ~flags_rd);
		end
	end

	// Unread flags and result-register fault marks, per channel
	generate
		for (g = 0; g < 4; g++) begin : g_unread
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					unread_r[g]        <= 1'b0;
					result_wd_mark[g]  <= 1'b0;
					result_amp_mark[g] <= 1'b0;
				end else begin
					unread_r[g] <= done_ev[g] | (unread_r[g] & ~result_read[g]);
					result_wd_mark[g] <= (wd_ev[g] & watchdog_to_result_enable_r)
						| (result_wd_mark[g] & ~result_read[g]);
					result_amp_mark[g] <= (ah_ev[g] & amp_high_to_result_enable_r)
						| (al_ev[g] & amp_low_to_result_enable_r)
						| (result_amp_mark[g] & ~result_read[g]);
				end
			end
		end
	endgenerate

	// Routing register writes; reserved bits are not stored
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_to_result_enable_r <= 1'b0;
			amp_high_to_result_enable_r <= 1'b0;
			amp_low_to_result_enable_r  <= 1'b0;
			watchdog_to_irq_enable_r    <= 1'b0;
			ready_to_irq_enable_r       <= 1'b0;
		end else if (reg_wr && (reg_addr == csf_pkg::ADDR_ROUTING)) begin
			watchdog_to_result_enable_r <= reg_wdata[csf_pkg::RT_WD2RES];
			amp_high_to_result_enable_r <= reg_wdata[csf_pkg::RT_AH2RES];
			amp_low_to_result_enable_r  <= reg_wdata[csf_pkg::RT_AL2RES];
			watchdog_to_irq_enable_r    <= reg_wdata[csf_pkg::RT_WD2IRQ];
			ready_to_irq_enable_r       <= reg_wdata[csf_pkg::RT_RDY2IRQ];
		end
	end

	// Interrupt latch: routed events set it, a flag read drops it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= ((|wd_ev) & watchdog_to_irq_enable_r)
				| (rdy_set & ready_to_irq_enable_r)
				| (irq_r & ~flags_rd);
		end
	end

	// Pin held off while disabled; registered so it never glitches
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_out_n <= 1'b1;
		end else begin
			irq_out_n <= ~(irq_r & ~irq_output_disable);
		end
	end

	// Read words; reserved bits tie to zero
	always_comb begin
		flags_word = csf_pkg::REG_RST;
		flags_word[csf_pkg::FLG_CHAN_HI:csf_pkg::FLG_CHAN_LO] = error_source_channel_r;
		flags_word[csf_pkg::FLG_WD]  = watchdog_timeout_flag_r;
		flags_word[csf_pkg::FLG_AHW] = amplitude_high_warning_r;
		flags_word[csf_pkg::FLG_ALW] = amplitude_low_warning_r;
		flags_word[csf_pkg::FLG_RDY] = conversion_ready_flag_r;
		for (int i = 0; i < 4; i++) begin
			flags_word[csf_pkg::FLG_UNREAD_HI - i] = unread_r[i];
		end
		routing_word = csf_pkg::REG_RST;
		routing_word[csf_pkg::RT_WD2RES]  = watchdog_to_result_enable_r;
		routing_word[csf_pkg::RT_AH2RES]  = amp_high_to_result_enable_r;
		routing_word[csf_pkg::RT_AL2RES]  = amp_low_to_result_enable_r;
		routing_word[csf_pkg::RT_WD2IRQ]  = watchdog_to_irq_enable_r;
		routing_word[csf_pkg::RT_RDY2IRQ] = ready_to_irq_enable_r;
	end

	// Read data captured the cycle after the strobe; flags read is pre-clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_r <= csf_pkg::REG_RST;
		end else if (reg_rd) begin
			case (reg_addr)
				csf_pkg::ADDR_FLAGS:   reg_rdata_r <= flags_word;
				csf_pkg::ADDR_ROUTING: reg_rdata_r <= routing_word;
				default:               reg_rdata_r <= csf_pkg::REG_RST;
			endcase
		end
	end
	assign reg_rdata = reg_rdata_r;

	// Checks
	sequence s_wd_routed;
		(|wd_ev) && watchdog_to_irq_enable_r && !irq_output_disable;
	endsequence
	sequence s_pin_low;
		!irq_out_n;
	endsequence

	property p_chan_range;
		@(posedge clock) disable iff (!reset_n)
		(NUM_CHAN <= 2) |-> (error_source_channel_r[1] == 1'b0 && unread_r[3:2] == 2'b00);
	endproperty
	a_chan_range: assert property (p_chan_range) else $error("channel code beyond build width");
	property p_wd_set;
		@(posedge clock) disable iff (!reset_n)
		(|wd_ev) |=> watchdog_timeout_flag_r;
	endproperty
	a_wd_set: assert property (p_wd_set) else $error("watchdog flag missed a timeout");
	property p_ah_set;
		@(posedge clock) disable iff (!reset_n)
		(|ah_ev) |=> flags_word[csf_pkg::FLG_AHW];
	endproperty
	a_ah_set: assert property (p_ah_set) else $error("amplitude high flag missed");
	property p_al_set;
		@(posedge clock) disable iff (!reset_n)
		(|al_ev) |=> flags_word[csf_pkg::FLG_ALW];
	endproperty
	a_al_set: assert property (p_al_set) else $error("amplitude low flag missed");
	property p_err_hold;
		@(posedge clock) disable iff (!reset_n)
		(watchdog_timeout_flag_r && !clear_err) |=> (watchdog_timeout_flag_r && $stable(error_source_channel_r));
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("latched error lost or source moved");
	property p_src_first;
		@(posedge clock) disable iff (!reset_n)
		(!err_latched && err_ev[0]) |=> (error_source_channel_r == 2'h0);
	endproperty
	a_src_first: assert property (p_src_first) else $error("source channel wrong");
	property p_rdy_quiet;
		@(posedge clock) disable iff (!reset_n)
		(!conversion_ready_flag_r && !rdy_set) |=> !conversion_ready_flag_r;
	endproperty
	a_rdy_quiet: assert property (p_rdy_quiet) else $error("ready flag rose without result");
	property p_single_rdy;
		@(posedge clock) disable iff (!reset_n)
		(conv_mode == csf_pkg::CSF_SINGLE && done_ev[active_chan]) |=> conversion_ready_flag_r;
	endproperty
	a_single_rdy: assert property (p_single_rdy) else $error("single mode ready missed");
	property p_seq_rdy;
		@(posedge clock) disable iff (!reset_n)
		($rose(conversion_ready_flag_r) && $past(conv_mode) == csf_pkg::CSF_SEQ)
			|-> (($past(fresh_r | done_ev) & $past(act_ok)) == $past(act_ok));
	endproperty
	a_seq_rdy: assert property (p_seq_rdy) else $error("sequential ready before all channels");
	property p_unread;
		@(posedge clock) disable iff (!reset_n)
		done_ev[0] |=> flags_word[csf_pkg::FLG_UNREAD_HI];
	endproperty
	a_unread: assert property (p_unread) else $error("channel 0 unread flag misplaced");
	property p_result_clear;
		@(posedge clock) disable iff (!reset_n)
		(result_read[1] && !done_ev[1]) |=> !unread_r[1];
	endproperty
	a_result_clear: assert property (p_result_clear) else $error("result read left unread flag");
	property p_irq_wd;
		@(posedge clock) disable iff (!reset_n)
		s_wd_routed ##1 !irq_output_disable |=> s_pin_low;
	endproperty
	a_irq_wd: assert property (p_irq_wd) else $error("watchdog interrupt missing");
	property p_irq_rdy;
		@(posedge clock) disable iff (!reset_n)
		(rdy_set && ready_to_irq_enable_r) ##1 !irq_output_disable |=> s_pin_low;
	endproperty
	a_irq_rdy: assert property (p_irq_rdy) else $error("ready interrupt missing");
	property p_res_wd;
		@(posedge clock) disable iff (!reset_n)
		(wd_ev[0] && watchdog_to_result_enable_r) |=> result_wd_mark[0];
	endproperty
	a_res_wd: assert property (p_res_wd) else $error("watchdog result mark missing");
	property p_irq_off;
		@(posedge clock) disable iff (!reset_n)
		irq_output_disable |=> irq_out_n;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt asserted while disabled");
endmodule : csf_status_flags

// file: include/csf_pkg.sv
// Constants shared by the conversion status flag block.
// Assumes an 8-bit register address and 16-bit registers from the serial port.
package csf_pkg;
	// Register addresses on the serial register port
	localparam logic [7:0] ADDR_FLAGS   = 8'h18;
	localparam logic [7:0] ADDR_ROUTING = 8'h19;
	localparam int         REG_W        = 16;
	localparam int         NUM_CHAN     = 4;

	// Flag register layout
	localparam int         FLG_CHAN_HI  = 15;
	localparam int         FLG_CHAN_LO  = 14;
	localparam int         FLG_WD       = 11;
	localparam int         FLG_AHW      = 10;
	localparam int         FLG_ALW      = 9;
	localparam int         FLG_RDY      = 6;
	localparam int         FLG_UNREAD_HI = 3;

	// Routing register layout
	localparam int         RT_WD2RES    = 13;
	localparam int         RT_AH2RES    = 12;
	localparam int         RT_AL2RES    = 11;
	localparam int         RT_WD2IRQ    = 5;
	localparam int         RT_RDY2IRQ   = 0;

	// Reset values
	localparam logic [1:0] CHAN_RST     = 2'h0;
	localparam logic [3:0] FLAGS4_RST   = 4'h0;
	localparam logic [15:0] REG_RST     = 16'h0000;

	// Conversion scheme
	typedef enum logic {
		CSF_SINGLE = 1'b0,
		CSF_SEQ    = 1'b1
	} csf_mode_t;
endpackage : csf_pkg

// file: verif/csf_host_model.sv
// Host model: register reads and writes plus result-register fetches.
// Assumes one-cycle strobes launched at the falling edge, read data one cycle later.
`timescale 1ns/1ps
module csf_host_model (
	// Clock
	input  wire logic        clock,
	// Register port
	output logic      [7:0]  reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	// Result register fetch strobes
	output logic      [3:0]  result_read
);
	// Quiet bus at time zero
	initial begin
		reg_addr    = 8'h00;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		reg_wdata   = 16'h0000;
		result_read = 4'h0;
	end

	// Released lines show the inverse, so a stale value never looks live
	task automatic release_bus();
		reg_addr  = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask : release_bus

	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(negedge clock);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		release_bus();
	endtask : write_reg

	// Data is taken one cycle after the strobe edge
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		d      = reg_rdata;
		release_bus();
	endtask : read_reg

	// Fetch the results of the channels set in the mask with a one-cycle strobe
	task automatic read_result(input logic [3:0] ch);
		@(negedge clock);
		result_read = ch;
		@(negedge clock);
		result_read = 4'h0;
	endtask : read_result
endmodule : csf_host_model

// file: verif/testbench.sv
// Testbench for the status flag bank, four-channel build plus a two-channel twin.
// Assumes the host model drives the register port; events are driven here.
`timescale 1ns/1ps
module testbench;
	logic               clock;
	logic               reset_n = 1'b0;
	wire logic [7:0]    reg_addr;
	wire logic          reg_wr;
	wire logic          reg_rd;
	wire logic [15:0]   reg_wdata;
	wire logic [3:0]    result_read;
	logic [15:0]        reg_rdata;
	logic [15:0]        rdata2;
	logic [3:0]         done_p = 4'h0;
	logic [3:0]         wd_p = 4'h0;
	logic [3:0]         ah_p = 4'h0;
	logic [3:0]         al_p = 4'h0;
	csf_pkg::csf_mode_t conv_mode = csf_pkg::CSF_SINGLE;
	logic [1:0]         active_chan = 2'h0;
	logic [3:0]         active_mask = 4'h0;
	logic               irq_dis = 1'b0;
	logic               irq_out_n;
	logic [3:0]         wd_mark;
	logic [3:0]         amp_mark;
	logic               irq2_n;
	logic [3:0]         wd_mark2;
	logic [3:0]         amp_mark2;
	int                 fails = 0;
	int                 check_count = 0;

	csf_status_flags uut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_read(result_read),
		.conv_done(done_p), .wd_timeout_evt(wd_p), .amp_high_evt(ah_p), .amp_low_evt(al_p),
		.conv_mode(conv_mode), .active_chan(active_chan), .active_mask(active_mask),
		.irq_output_disable(irq_dis), .irq_out_n(irq_out_n), .result_wd_mark(wd_mark),
		.result_amp_mark(amp_mark));
	// Two-channel build sharing every input
	csf_status_flags #(.NUM_CHAN(2)) uut2 (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata2),
		.result_read(result_read), .conv_done(done_p), .wd_timeout_evt(wd_p), .amp_high_evt(ah_p),
		.amp_low_evt(al_p), .conv_mode(conv_mode), .active_chan(active_chan),
		.active_mask(active_mask), .irq_output_disable(irq_dis), .irq_out_n(irq2_n),
		.result_wd_mark(wd_mark2), .result_amp_mark(amp_mark2));
	csf_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_read(result_read));

	// Clock, 4 ns period
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic check_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check_reg

	task automatic check_pin(input logic [3:0] got, input logic [3:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check_pin

	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
		logic [15:0] d;
		host.read_reg(a, d);
		check_reg(d, exp, what);
	endtask : rd

	// One-cycle event pulses on the channels set in each mask
	task automatic ev(input logic [3:0] d, input logic [3:0] w, input logic [3:0] h, input logic [3:0] l);
		@(negedge clock);
		done_p = d;
		wd_p   = w;
		ah_p   = h;
		al_p   = l;
		@(negedge clock);
		done_p = 4'h0;
		wd_p   = 4'h0;
		ah_p   = 4'h0;
		al_p   = 4'h0;
	endtask : ev

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic t_reset();
		rd(8'h18, 16'h0000, "flags after reset");
		rd(8'h19, 16'h0000, "routing after reset");
		rd(8'h20, 16'h0000, "unmapped read");
		check_pin({3'h0, irq_out_n}, 4'h1, "pin idle");
		host.write_reg(8'h18, 16'hffff);
		rd(8'h18, 16'h0000, "flags not writable");
		host.write_reg(8'h19, 16'hffff);
		rd(8'h19, 16'h3821, "routing bits only");
		$display("test reset done");
	endtask : t_reset

	task automatic t_watchdog();
		ev(4'h0, 4'h4, 4'h0, 4'h0);
		repeat (2) @(negedge clock);
		check_pin({3'h0, irq_out_n}, 4'h0, "pin on timeout");
		check_pin(wd_mark, 4'h4, "result mark");
		check_pin({3'h0, irq2_n}, 4'h1, "two-channel pin ignores channel 2");
		check_pin(wd_mark2, 4'h0, "two-channel mark ignores channel 2");
		rd(8'h18, 16'h8800, "timeout flag");
		repeat (2) @(negedge clock);
		check_pin({3'h0, irq_out_n}, 4'h1, "pin freed by read");
		rd(8'h18, 16'h8000, "timeout cleared");
		host.read_result(4'h4);
		check_pin(wd_mark, 4'h0, "mark cleared");
		$display("test watchdog done");
	endtask : t_watchdog

	// Source frozen while held; a flag read or the source result read releases, another result read does not
	task automatic t_amp();
		ev(4'h0, 4'h0, 4'h2, 4'h8);
		ev(4'h0, 4'h1, 4'h0, 4'h0);
		rd(8'h18, 16'h4e00, "held errors");
		check_reg(rdata2, 16'h4c00, "two-channel build");
		check_pin(amp_mark, 4'ha, "amplitude result marks");
		check_pin(amp_mark2, 4'h2, "two-channel amplitude marks");
		rd(8'h18, 16'h4000, "errors cleared");
		ev(4'h0, 4'h0, 4'h0, 4'h4);
		host.read_result(4'h2);
		rd(8'h18, 16'h8200, "other result read");
		ev(4'h0, 4'h0, 4'h4, 4'h0);
		host.read_result(4'h4);
		rd(8'h18, 16'h8000, "source result read");
		check_pin(amp_mark, 4'h8, "marks cleared by result reads");
		$display("test amplitude done");
	endtask : t_amp

	task automatic t_single();
		active_chan = 2'h1;
		ev(4'h2, 4'h0, 4'h0, 4'h0);
		repeat (2) @(negedge clock);
		check_pin({3'h0, irq_out_n}, 4'h0, "pin on ready");
		rd(8'h18, 16'h8044, "ready and unread");
		host.read_result(4'h2);
		rd(8'h18, 16'h8000, "unread cleared");
		irq_dis = 1'b1;
		ev(4'h2, 4'h0, 4'h0, 4'h0);
		repeat (2) @(negedge clock);
		check_pin({3'h0, irq_out_n}, 4'h1, "pin disabled");
		rd(8'h18, 16'h8044, "flags still set");
		host.read_result(4'h2);
		irq_dis = 1'b0;
		$display("test single done");
	endtask : t_single

	task automatic t_seq();
		conv_mode   = csf_pkg::CSF_SEQ;
		active_mask = 4'h5;
		ev(4'h1, 4'h0, 4'h0, 4'h0);
		rd(8'h18, 16'h8008, "no ready yet");
		ev(4'h4, 4'h0, 4'h0, 4'h0);
		rd(8'h18, 16'h804a, "ready after all");
		host.read_result(4'h5);
		rd(8'h18, 16'h8000, "both read");
		$display("test sequential done");
	endtask : t_seq

	// Main sequence, reset held two cycles
	initial begin
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		t_reset();
		t_watchdog();
		t_amp();
		t_single();
		t_seq();
		test_done();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge clock);
		fails++;
		test_done();
	end
endmodule : testbench
